/* pkg/ppc_defines.svh */
// Offsets, field positions, reset values and match constants for the port register bank
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
`define PPC_ADDR_W 9
`define PPC_OFS_CTRL 9'h104
`define PPC_OFS_TX_DETECT 9'h158
`define PPC_OFS_CF_HIGH 9'h180
`define PPC_OFS_CF_LOW 9'h184
`define PPC_OFS_CHK_DROP 9'h188
`define PPC_OFS_FLT_DROP 9'h18C
`define PPC_CTRL_BANK_LSB 0
`define PPC_CTRL_AUTO_BIT 8
`define PPC_BANK_RX 3'h1
`define PPC_BANK_TX 3'h2
`define PPC_CF_LOW_LSB 16
`define PPC_TXD_L2_ONE 14
`define PPC_TXD_L2_TWO 13
`define PPC_TXD_IP_ONE 12
`define PPC_TXD_IP_TWO 11
`define PPC_TXD_RESET 4'hE
`define PPC_CNT_MAX 32'hFFFFFFFF
`define PPC_MAC_L2_ONE 48'h0180C200000E
`define PPC_MAC_L2_TWO 48'h011B19000000
`define PPC_MAC_V4_BASE 40'h01005E0001
`define PPC_MAC_V6_BASE 40'h3333000001
`define PPC_IP4_BASE 24'hE00001
`define PPC_IP_ONE_LO 8'h81
`define PPC_IP_TWO_LO 8'h82
`define PPC_IP6_TOP 8'hFF
`define PPC_IP6_MID 108'h0
`define PPC_IP6_LO_HI 8'h01
`endif

/* pkg/ppc_pkg.sv */
// Types shared by the port register bank
package ppc_pkg;
    // One register access from software
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [31:0] wdata;
    } ppc_bus_req_s;

    // Transmit frame header handed over for PTP detection
    typedef struct packed {
        logic valid;
        logic is_ipv4;
        logic is_ipv6;
        logic [47:0] mac_da;
        logic [127:0] ip_da;
    } ppc_tx_probe_s;

    // Receive-side drop and peer-delay events
    typedef struct packed {
        logic pdreq_seen;
        logic [63:0] correction;
        logic checksum_drop;
        logic filter_drop;
    } ppc_rx_event_s;
endpackage

/* core/ppc_port_regs.sv */
// Per-port PTP register bank: peer-delay correction, drop tallies, transmit detection
//
// What this block does
// - High register holds correction bits 63:32
// - Low register bits 31:16 hold correction 31:16
// - Fractional bits below 16 never stored
// - Auto update overwrites both on peer-delay request
// - Count each bad-checksum ingress drop
// - Every tallied drop flagged to receiving MAC
// - Count each message-filter ingress drop
// - Both tallies saturate at all ones
// - Writing zero clears a tally
// - Bit 14 accepts 01:80:C2:00:00:0E
// - Bit 13 accepts 01:1B:19:00:00:00
// - Bit 12 accepts IPv4 address one
// - Bit 12 accepts IPv6 address one
// - Bit 11 accepts IPv4 address two
// - Bit 11 accepts IPv6 address two
// - Bank select chooses window before access
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"

module ppc_port_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire ppc_pkg::ppc_bus_req_s bus_req,
    output logic [31:0] bus_rdata,
    input wire ppc_pkg::ppc_rx_event_s rx_event,
    output logic rx_mac_error,
    input wire ppc_pkg::ppc_tx_probe_s tx_probe,
    output logic tx_ptp_match,
    output logic auto_update
);

    logic [2:0] bank_sel;
    logic [31:0] cf_high;
    logic [15:0] cf_low;
    logic [31:0] chk_tally;
    logic [31:0] flt_tally;
    logic [3:0] tx_detect;
    logic rx_win;
    logic tx_win;
    logic wr_ctrl;
    logic wr_txd;
    logic wr_cf_high;
    logic wr_cf_low;
    logic wr_chk;
    logic wr_flt;
    logic [31:0] next_rdata;
    logic next_match;

    // Saturating increment shared by both tallies
    function automatic logic [31:0] sat_inc(input logic [31:0] cnt);
        if (cnt == `PPC_CNT_MAX) begin
            return cnt;
        end
        return cnt + 32'h00000001;
    endfunction

    // IPv4 or IPv6 multicast destination ending in the given low byte
    function automatic logic ip_hit(input ppc_pkg::ppc_tx_probe_s p, input logic [7:0] lo);
        logic v4;
        logic v6;
        v4 = p.is_ipv4 && (p.mac_da == {`PPC_MAC_V4_BASE, lo})
            && (p.ip_da[31:0] == {`PPC_IP4_BASE, lo});
        // Scope nibble of FF0X is left free
        v6 = p.is_ipv6 && (p.mac_da == {`PPC_MAC_V6_BASE, lo})
            && (p.ip_da[127:120] == `PPC_IP6_TOP) && (p.ip_da[119:116] == 4'h0)
            && (p.ip_da[111:16] == 96'h0) && (p.ip_da[15:0] == {`PPC_IP6_LO_HI, lo});
        return v4 || v6;
    endfunction

    // Window decode follows the bank select field
    assign rx_win = (bank_sel == `PPC_BANK_RX);
    assign tx_win = (bank_sel == `PPC_BANK_TX);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == `PPC_OFS_CTRL);
    assign wr_txd = bus_req.wr && tx_win && (bus_req.addr == `PPC_OFS_TX_DETECT);
    assign wr_cf_high = bus_req.wr && rx_win && (bus_req.addr == `PPC_OFS_CF_HIGH);
    assign wr_cf_low = bus_req.wr && rx_win && (bus_req.addr == `PPC_OFS_CF_LOW);
    assign wr_chk = bus_req.wr && rx_win && (bus_req.addr == `PPC_OFS_CHK_DROP);
    assign wr_flt = bus_req.wr && rx_win && (bus_req.addr == `PPC_OFS_FLT_DROP);

    // Global control: bank select and auto-update; not banked so it is always reachable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bank_sel <= 3'h0;
            auto_update <= 1'b0;
        end else if (wr_ctrl) begin
            bank_sel <= bus_req.wdata[`PPC_CTRL_BANK_LSB +: 3];
            auto_update <= bus_req.wdata[`PPC_CTRL_AUTO_BIT];
        end
    end

    // Correction high word; a received request wins over a host write in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cf_high <= 32'h00000000;
        end else if (rx_event.pdreq_seen && auto_update) begin
            cf_high <= rx_event.correction[63:32];
        end else if (wr_cf_high) begin
            cf_high <= bus_req.wdata;
        end
    end

    // Correction low word keeps only nanoseconds; fractional bits are dropped on entry
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cf_low <= 16'h0000;
        end else if (rx_event.pdreq_seen && auto_update) begin
            cf_low <= rx_event.correction[31:16];
        end else if (wr_cf_low) begin
            cf_low <= bus_req.wdata[31:16];
        end
    end

    // Bad-checksum tally; host write has priority so a clear is exact
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chk_tally <= 32'h00000000;
        end else if (wr_chk) begin
            chk_tally <= bus_req.wdata;
        end else if (rx_event.checksum_drop) begin
            chk_tally <= sat_inc(chk_tally);
        end
    end

    // Filtered tally, same policy
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flt_tally <= 32'h00000000;
        end else if (wr_flt) begin
            flt_tally <= bus_req.wdata;
        end else if (rx_event.filter_drop) begin
            flt_tally <= sat_inc(flt_tally);
        end
    end

    // Each tallied drop is also flagged to the MAC one cycle later
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_mac_error <= 1'b0;
        end else begin
            rx_mac_error <= rx_event.checksum_drop || rx_event.filter_drop;
        end
    end

    // Detect enables; no interlock against the global enable, software must honour that
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_detect <= `PPC_TXD_RESET;
        end else if (wr_txd) begin
            tx_detect <= bus_req.wdata[`PPC_TXD_IP_TWO +: 4];
        end
    end

    // Destination match against enabled addresses
    always_comb begin
        next_match = 1'b0;
        if (tx_probe.valid) begin
            if (tx_detect[`PPC_TXD_L2_ONE - `PPC_TXD_IP_TWO]
                && tx_probe.mac_da == `PPC_MAC_L2_ONE) begin
                next_match = 1'b1;
            end
            if (tx_detect[`PPC_TXD_L2_TWO - `PPC_TXD_IP_TWO]
                && tx_probe.mac_da == `PPC_MAC_L2_TWO) begin
                next_match = 1'b1;
            end
            if (tx_detect[`PPC_TXD_IP_ONE - `PPC_TXD_IP_TWO]
                && ip_hit(tx_probe, `PPC_IP_ONE_LO)) begin
                next_match = 1'b1;
            end
            if (tx_detect[0] && ip_hit(tx_probe, `PPC_IP_TWO_LO)) begin
                next_match = 1'b1;
            end
        end
    end

    // Registered so the verdict is glitch free
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_ptp_match <= 1'b0;
        end else begin
            tx_ptp_match <= next_match;
        end
    end

    // Read mux; registers outside the selected bank and unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h00000000;
        case (bus_req.addr)
            `PPC_OFS_CTRL: begin
                next_rdata[`PPC_CTRL_BANK_LSB +: 3] = bank_sel;
                next_rdata[`PPC_CTRL_AUTO_BIT] = auto_update;
            end
            `PPC_OFS_TX_DETECT: begin
                if (tx_win) begin
                    next_rdata[`PPC_TXD_IP_TWO +: 4] = tx_detect;
                end
            end
            `PPC_OFS_CF_HIGH: begin
                if (rx_win) begin
                    next_rdata = cf_high;
                end
            end
            `PPC_OFS_CF_LOW: begin
                if (rx_win) begin
                    next_rdata = {cf_low, 16'h0000};
                end
            end
            `PPC_OFS_CHK_DROP: begin
                if (rx_win) begin
                    next_rdata = chk_tally;
                end
            end
            `PPC_OFS_FLT_DROP: begin
                if (rx_win) begin
                    next_rdata = flt_tally;
                end
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus_rdata <= 32'h00000000;
        end else if (bus_req.rd) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= 32'h00000000;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_cf_high_cap: assert property (
        rx_event.pdreq_seen && auto_update |=> cf_high == $past(rx_event.correction[63:32]))
        else $error("high correction not captured");

    a_cf_low_cap: assert property (
        rx_event.pdreq_seen && auto_update
        |=> cf_low == $past(rx_event.correction[31:16]))
        else $error("low correction not captured");

    a_cf_low_res: assert property (
        bus_req.rd && bus_req.addr == `PPC_OFS_CF_LOW |=> bus_rdata[15:0] == 16'h0000)
        else $error("reserved low bits not zero");

    a_cf_hold: assert property (
        !auto_update && !wr_cf_high |=> $stable(cf_high))
        else $error("correction changed without auto update");

    a_chk_step: assert property (
        rx_event.checksum_drop && !wr_chk && chk_tally != `PPC_CNT_MAX
        |=> chk_tally == $past(chk_tally) + 32'h00000001)
        else $error("checksum tally did not step by one");

    a_flt_step: assert property (
        rx_event.filter_drop && !wr_flt && flt_tally != `PPC_CNT_MAX
        |=> flt_tally == $past(flt_tally) + 32'h00000001)
        else $error("filter tally did not step by one");

    a_tally_sat: assert property (
        chk_tally == `PPC_CNT_MAX && !wr_chk |=> chk_tally == `PPC_CNT_MAX)
        else $error("checksum tally wrapped");

    a_tally_clear: assert property (
        wr_flt && bus_req.wdata == 32'h00000000 |=> flt_tally == 32'h00000000)
        else $error("filter tally not cleared");

    a_mac_error: assert property (
        (rx_event.checksum_drop || rx_event.filter_drop) |=> rx_mac_error
        ##0 $past(rx_event.checksum_drop || rx_event.filter_drop) == rx_mac_error)
        else $error("drop not flagged to MAC");

    a_l2_match: assert property (
        tx_probe.valid && tx_probe.mac_da == `PPC_MAC_L2_ONE && tx_detect[3] |=> tx_ptp_match)
        else $error("layer 2 address one not matched");

    a_bank_gate: assert property (
        bus_req.rd && !rx_win && bus_req.addr == `PPC_OFS_CHK_DROP |=> bus_rdata == 32'h0)
        else $error("register visible outside its bank");

endmodule
`default_nettype wire

/* verification/test_ppc_port_regs.sv */
// Self-checking bench for the per-port PTP register bank
`timescale 1ns/1ps
`default_nettype none

module test_ppc_port_regs;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    ppc_pkg::ppc_bus_req_s bus_req = '0;
    ppc_pkg::ppc_rx_event_s rx_event = '0;
    ppc_pkg::ppc_tx_probe_s tx_probe = '0;
    logic [31:0] bus_rdata;
    logic rx_mac_error;
    logic tx_ptp_match;
    logic auto_update;
    int fail_count = 0;
    int cmp_count = 0;
    logic [47:0] mac_t [6] = '{48'h0180C200000E, 48'h011B19000000, 48'h01005E000181,
        48'h333300000181, 48'h01005E000182, 48'h333300000182};
    int bit_t [6] = '{14, 13, 12, 12, 11, 11};
    logic [31:0] cfg;

    ppc_port_regs uut (
        .mclk(mclk),
        .rst_n(rst_n),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .rx_event(rx_event),
        .rx_mac_error(rx_mac_error),
        .tx_probe(tx_probe),
        .tx_ptp_match(tx_ptp_match),
        .auto_update(auto_update)
    );

    // 20 MHz clock
    always #25 mclk = ~mclk;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_req <= {1'b1, 1'b0, a, d};
        @(posedge mclk);
        bus_req <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        @(posedge mclk);
        bus_req <= {1'b0, 1'b1, a, 32'h0};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        chk($sformatf("rdata at %h", a), e, bus_rdata);
    endtask

    // Holds an event for n cycles; error flag must follow each drop cycle
    task automatic pulse(input ppc_pkg::ppc_rx_event_s ev, input int n);
        @(posedge mclk);
        rx_event <= ev;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            // Release on the edge that takes the last event cycle
            if (i == n - 1) begin
                rx_event <= '0;
            end
            #1;
            chk("rx_mac_error", {31'h0, ev.checksum_drop | ev.filter_drop}, {31'h0, rx_mac_error});
        end
    endtask

    // One header per table entry, match judged against the enabled bits
    task automatic probe_all(input logic [31:0] c);
        logic [7:0] lo;
        logic [127:0] ip;
        for (int i = 0; i < 6; i++) begin
            lo = (i < 4) ? 8'h81 : 8'h82;
            ip = (i % 2 == 0) ? {96'h0, 24'hE00001, lo} : {16'hFF05, 96'h0, 8'h01, lo};
            if (i < 2) ip = '0;
            @(posedge mclk);
            tx_probe <= {1'b1, i == 2 || i == 4, i == 3 || i == 5, mac_t[i], ip};
            @(posedge mclk);
            tx_probe <= '0;
            #1;
            chk($sformatf("match %0d", i), {31'h0, c[bit_t[i]]}, {31'h0, tx_ptp_match});
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the under two hundred cycles the sequence needs
    initial begin
        repeat (4000) @(posedge mclk);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("auto_update", 32'h0, {31'h0, auto_update});
        wr(9'h104, 32'h1);
        rd(9'h180, 32'h0);
        rd(9'h184, 32'h0);
        rd(9'h188, 32'h0);
        rd(9'h18C, 32'h0);
        wr(9'h104, 32'h101);
        #1;
        chk("auto_update", 32'h1, {31'h0, auto_update});
        pulse({1'b1, 64'h0123456789ABCDEF, 2'b00}, 1);
        rd(9'h180, 32'h01234567);
        rd(9'h184, 32'h89AB0000);
        // Auto off: captures must be ignored, host owns the fields
        wr(9'h104, 32'h1);
        pulse({1'b1, 64'hFFFFFFFF55555555, 2'b00}, 1);
        rd(9'h180, 32'h01234567);
        wr(9'h180, 32'hDEADBEEF);
        rd(9'h180, 32'hDEADBEEF);
        wr(9'h184, 32'hFFFFFFFF);
        rd(9'h184, 32'hFFFF0000);
        // Back-to-back drops, then both kinds in one cycle
        pulse({1'b0, 64'h0, 2'b10}, 3);
        rd(9'h188, 32'h3);
        pulse({1'b0, 64'h0, 2'b11}, 2);
        rd(9'h188, 32'h5);
        rd(9'h18C, 32'h2);
        wr(9'h188, 32'h0);
        rd(9'h188, 32'h0);
        wr(9'h18C, 32'hFFFFFFFE);
        pulse({1'b0, 64'h0, 2'b01}, 3);
        rd(9'h18C, 32'hFFFFFFFF);
        // Checksum tally must stick at all ones too
        wr(9'h188, 32'hFFFFFFFF);
        pulse({1'b0, 64'h0, 2'b10}, 2);
        rd(9'h188, 32'hFFFFFFFF);
        // Host write and increment in the same cycle: write wins
        @(posedge mclk);
        bus_req <= {1'b1, 1'b0, 9'h188, 32'h7};
        rx_event <= {1'b0, 64'h0, 2'b10};
        @(posedge mclk);
        bus_req <= '0;
        rx_event <= '0;
        rd(9'h188, 32'h7);
        rd(9'h1F0, 32'h0);
        // Wrong bank hides the tallies and drops writes to them
        wr(9'h104, 32'h2);
        rd(9'h188, 32'h0);
        wr(9'h18C, 32'h0);
        rd(9'h158, 32'h7000);
        probe_all(32'h7000);
        for (int k = 0; k < 4; k++) begin
            cfg = 32'h800 << k;
            wr(9'h158, cfg);
            rd(9'h158, cfg);
            probe_all(cfg);
        end
        wr(9'h104, 32'h1);
        rd(9'h18C, 32'hFFFFFFFF);
        rd(9'h158, 32'h0);
        // Clear the saturated filter tally from its own bank
        wr(9'h18C, 32'h0);
        rd(9'h18C, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
